// ---- common/instr_exec_pkg.sv ----
/*
  Constants, types and opcode layout for the return/rotate execution block.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
// Summary of operation
// - irq return pops the stack into the program counter, two cycles.
// - irq return sets global irq allow, bit 7; no status flags change.
// - return literal loads its 8-bit literal into the accumulator, flags untouched.
// - return literal pops the stack into the program counter, two cycles.
// - plain return pops stack into program counter; flags, irq enable untouched; two cycles.
// - rotate left through carry; old carry to bit 0, bit 7 to carry.
// - destination bit 0 writes accumulator, 1 writes back the file register.
package instr_exec_pkg;

  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int PC_W    = 13;
  localparam int FADDR_W = 7;

  typedef logic [INSTR_W-1:0] instr_t;
  typedef logic [DATA_W-1:0]  data_t;
  typedef logic [PC_W-1:0]    pc_t;
  typedef logic [FADDR_W-1:0] faddr_t;

  // ------------------------------------------------------------------
  // instruction layout
  // ------------------------------------------------------------------
  localparam int OPC_MSB   = 13;
  localparam int OPC_LSB   = 8;
  localparam int DEST_BIT  = 7;
  localparam int FADDR_MSB = 6;
  localparam int LIT_MSB   = 7;

  // opcode values are arbitrary
  localparam logic [5:0] OPC_MISC   = 6'h00;
  localparam logic [5:0] OPC_RETLIT = 6'h30;
  localparam logic [5:0] OPC_ROTL   = 6'h20;
  localparam data_t      SUB_IDLE   = 8'h00;
  localparam data_t      SUB_RET    = 8'h01;
  localparam data_t      SUB_IRQRET = 8'h02;

  // position of the irq enable inside the irq control register
  localparam int IRQ_ALLOW_BIT = 7;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam pc_t   PC_RST    = 13'h0000;
  localparam data_t ACC_RST   = 8'h00;
  localparam logic  CARRY_RST = 1'b0;
  localparam logic  IRQ_ALLOW_RST = 1'b0;
  localparam pc_t   PC_STEP   = 13'h0001;

  typedef enum logic [2:0] {
    OP_IDLE    = 3'b000,
    OP_RET     = 3'b001,
    OP_IRQRET  = 3'b010,
    OP_RETLIT  = 3'b011,
    OP_ROTL    = 3'b100,
    OP_FOREIGN = 3'b101
  } op_e;

  typedef enum logic {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } exec_state_e;

endpackage : instr_exec_pkg

// ---- common/rot_if.sv ----
/*
  Carrier between the execution block and its rotate unit.
  Assumes both ends sit on the same clock; purely combinational path.
*/
`timescale 1ns/1ps
interface rot_if;
  import instr_exec_pkg::*;
  data_t src;
  logic  carry_in;
  data_t result;
  logic  carry_out;

  modport unit (input src, input carry_in, output result, output carry_out);
  modport user (output src, output carry_in, input result, input carry_out);
endinterface : rot_if

// ---- rtl/rotate_unit.sv ----
/*
  Rotate-left-through-carry datapath.
  Assumes the caller registers the result and the new carry.
*/
`timescale 1ns/1ps
module rotate_unit (
  rot_if.unit r
);
  import instr_exec_pkg::*;

  // ------------------------------------------------------------------
  // rotate
  // ------------------------------------------------------------------
  always_comb begin
    r.result    = {r.src[DATA_W-2:0], r.carry_in};
    r.carry_out = r.src[DATA_W-1];
  end

endmodule : rotate_unit

// ---- rtl/return_rotate_instr_exec.sv ----
/*
  Executes idle, return, irq return, return-with-literal and rotate-left
  through carry. Holds the program counter, accumulator, carry flag and the
  global irq enable.
  Assumes a combinational file-register read port and a return stack whose
  top entry is valid whenever a return is presented.
*/
`timescale 1ns/1ps
module return_rotate_instr_exec (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // instruction issue
  input  wire logic                  instr_valid,
  input  wire instr_exec_pkg::instr_t instr,
  output logic                       instr_ready,
  output logic                       foreign_op,
  // return stack
  input  wire instr_exec_pkg::pc_t   stack_top_entry,
  output logic                       stack_pop,
  // file register read
  output instr_exec_pkg::faddr_t     file_raddr,
  input  wire instr_exec_pkg::data_t file_rdata,
  // file register write
  output logic                       file_we,
  output instr_exec_pkg::faddr_t     file_waddr,
  output instr_exec_pkg::data_t      file_wdata,
  // interrupt entry
  input  wire logic                  irq_entry,
  // core state
  output instr_exec_pkg::pc_t        pc,
  output instr_exec_pkg::data_t      acc,
  output logic                       carry,
  output logic                       global_irq_allow,
  output instr_exec_pkg::data_t      irq_control_reg
);
  import instr_exec_pkg::*;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  function automatic op_e decode_op(input instr_t iw);
    op_e op;
    op = OP_FOREIGN;
    if (iw[OPC_MSB:OPC_LSB] == OPC_MISC) begin
      if (iw[LIT_MSB:0] == SUB_IDLE) begin
        op = OP_IDLE;
      end else if (iw[LIT_MSB:0] == SUB_RET) begin
        op = OP_RET;
      end else if (iw[LIT_MSB:0] == SUB_IRQRET) begin
        op = OP_IRQRET;
      end
    end else if (iw[OPC_MSB:OPC_LSB] == OPC_RETLIT) begin
      op = OP_RETLIT;
    end else if (iw[OPC_MSB:OPC_LSB] == OPC_ROTL) begin
      op = OP_ROTL;
    end
    return op;
  endfunction : decode_op

  op_e         op;
  logic        take;
  exec_state_e state_reg;
  exec_state_e state_next;
  pc_t         pc_reg;
  pc_t         pc_next;
  data_t       acc_reg;
  data_t       acc_next;
  logic        carry_reg;
  logic        carry_next;
  logic        irq_allow_reg;
  logic        irq_allow_next;
  logic        we_reg;
  logic        we_next;
  faddr_t      waddr_reg;
  faddr_t      waddr_next;
  data_t       wdata_reg;
  data_t       wdata_next;

  rot_if rot ();

  rotate_unit u_rotate (
    .r (rot.unit)
  );

  assign op          = decode_op(instr);
  assign instr_ready = (state_reg == ST_EXEC);
  assign take        = instr_valid && instr_ready;
  assign file_raddr  = instr[FADDR_MSB:0];
  assign rot.src     = file_rdata;
  assign rot.carry_in = carry_reg;

  // ------------------------------------------------------------------
  // handshake outputs
  // ------------------------------------------------------------------
  always_comb begin
    stack_pop  = take && (op == OP_RET || op == OP_IRQRET || op == OP_RETLIT);
    foreign_op = take && (op == OP_FOREIGN);
  end

  // ------------------------------------------------------------------
  // sequencing: two-cycle ops spend a flush cycle after the pop
  // ------------------------------------------------------------------
  always_comb begin
    state_next = ST_EXEC;
    unique case (state_reg)
      ST_EXEC: begin
        if (stack_pop) begin
          state_next = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        state_next = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_EXEC;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // program counter
  // ------------------------------------------------------------------
  always_comb begin
    pc_next = pc_reg;
    if (take) begin
      if (stack_pop) begin
        pc_next = stack_top_entry;
      end else begin
        pc_next = pc_reg + PC_STEP;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_reg <= PC_RST;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // ------------------------------------------------------------------
  // accumulator and carry
  // ------------------------------------------------------------------
  always_comb begin
    acc_next   = acc_reg;
    carry_next = carry_reg;
    if (take && op == OP_RETLIT) begin
      acc_next = instr[LIT_MSB:0];
    end
    if (take && op == OP_ROTL) begin
      carry_next = rot.carry_out;
      if (!instr[DEST_BIT]) begin
        acc_next = rot.result;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      acc_reg   <= ACC_RST;
      carry_reg <= CARRY_RST;
    end else begin
      acc_reg   <= acc_next;
      carry_reg <= carry_next;
    end
  end

  // ------------------------------------------------------------------
  // global irq enable: set by irq return wins over entry clear
  // ------------------------------------------------------------------
  always_comb begin
    irq_allow_next = irq_allow_reg;
    if (irq_entry) begin
      irq_allow_next = 1'b0;
    end
    if (take && op == OP_IRQRET) begin
      irq_allow_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_allow_reg <= IRQ_ALLOW_RST;
    end else begin
      irq_allow_reg <= irq_allow_next;
    end
  end

  // ------------------------------------------------------------------
  // file register write-back
  // ------------------------------------------------------------------
  always_comb begin
    we_next    = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    if (take && op == OP_ROTL && instr[DEST_BIT]) begin
      we_next    = 1'b1;
      waddr_next = instr[FADDR_MSB:0];
      wdata_next = rot.result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      we_reg    <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= ACC_RST;
    end else begin
      we_reg    <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  always_comb begin
    pc               = pc_reg;
    acc              = acc_reg;
    carry            = carry_reg;
    global_irq_allow = irq_allow_reg;
    irq_control_reg  = '0;
    irq_control_reg[IRQ_ALLOW_BIT] = irq_allow_reg;
    file_we          = we_reg;
    file_waddr       = waddr_reg;
    file_wdata       = wdata_reg;
  end

endmodule : return_rotate_instr_exec

// ---- testbench/instr_exec_asserts.sv ----
/* port-level checks for the return/rotate execution block.
   assumes it is bound onto return_rotate_instr_exec and sees only its ports. */
`timescale 1ns/1ps
module instr_exec_asserts (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  // issue
  input wire logic                   instr_valid,
  input wire instr_exec_pkg::instr_t instr,
  input wire logic                   instr_ready,
  input wire logic                   foreign_op,
  // stack and file
  input wire instr_exec_pkg::pc_t    stack_top_entry,
  input wire logic                   stack_pop,
  input wire instr_exec_pkg::faddr_t file_raddr,
  input wire instr_exec_pkg::data_t  file_rdata,
  input wire logic                   file_we,
  input wire instr_exec_pkg::faddr_t file_waddr,
  input wire instr_exec_pkg::data_t  file_wdata,
  input wire logic                   irq_entry,
  // core state
  input wire instr_exec_pkg::pc_t    pc,
  input wire instr_exec_pkg::data_t  acc,
  input wire logic                   carry,
  input wire logic                   global_irq_allow,
  input wire instr_exec_pkg::data_t  irq_control_reg
);
  import instr_exec_pkg::*;
  wire tk   = instr_valid && instr_ready;
  wire misc = tk && instr[13:8] == OPC_MISC;
  wire rl   = tk && instr[13:8] == OPC_RETLIT;
  wire rot  = tk && instr[13:8] == OPC_ROTL;
  wire ir   = misc && instr[7:0] == SUB_IRQRET;
  wire rt   = misc && instr[7:0] == SUB_RET;
  wire id   = misc && instr[7:0] == SUB_IDLE;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pop_on_ret:
    assert property ((ir || rt || rl) |-> stack_pop) else $error("no pop on return");
  a_ret_two_cycles:
    assert property ((ir || rt || rl) |=> pc == $past(stack_top_entry) && !instr_ready ##1 instr_ready)
      else $error("return timing or target wrong");
  a_irqret_enable:
    assert property (ir |=> global_irq_allow && irq_control_reg == 8'h80) else $error("enable not set");
  a_lit_to_acc:
    assert property (rl |=> acc == $past(instr[7:0]) && $stable(carry)) else $error("literal not loaded");
  a_ret_keeps:
    assert property (rt && !irq_entry |=> $stable(global_irq_allow) && $stable(acc) && $stable(carry))
      else $error("return changed state");
  a_rot_carry:
    assert property (rot |=> carry == $past(file_rdata[7])) else $error("rotate carry wrong");
  a_rot_to_acc:
    assert property (rot && !instr[7] |=> acc == {$past(file_rdata[6:0]), $past(carry)} && !file_we)
      else $error("rotate to acc wrong");
  a_rot_back:
    assert property (rot && instr[7] |=> file_we && file_waddr == $past(instr[6:0]) &&
      file_wdata == {$past(file_rdata[6:0]), $past(carry)} && $stable(acc)) else $error("write back wrong");
  a_idle_step:
    assert property (id |=> pc == $past(pc) + PC_STEP && $stable(acc) && $stable(carry) && !file_we)
      else $error("idle changed state");
endmodule : instr_exec_asserts

bind return_rotate_instr_exec instr_exec_asserts i_instr_exec_asserts (.*);

// ---- testbench/tb.sv ----
/* self-checking bench: random instruction stream against an integer model.
   assumes accept on ready and one dead cycle after each return-type op. */
`timescale 1ns/1ps
module tb;
  import instr_exec_pkg::*;
  logic clk_sys, rst_n, instr_valid, instr_ready, foreign_op, stack_pop, file_we, irq_entry;
  logic carry, global_irq_allow;
  instr_t instr;
  pc_t stack_top_entry, pc;
  faddr_t file_raddr, file_waddr;
  data_t file_rdata, file_wdata, acc, irq_control_reg;
  int num_errors, checks, m_pc, m_acc, m_c, m_g;
  logic [31:0] seed = 32'h6601c395;

  return_rotate_instr_exec i_return_rotate_instr_exec (.*);

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic results();
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // k: 0 idle, 1 return, 2 irq return, 3 return literal, 4 rotate, 5 foreign
  task automatic op(input int k);
    logic [31:0] r;
    int n, rot, ret, we;
    r = rnd();
    n = 0;
    while (instr_ready !== 1'b1) begin
      irq_entry = 0;
      @(posedge clk_sys);
      #1;
      if (++n > 20) begin
        num_errors++;
        results();
      end
    end
    case (k)
      0: instr = {OPC_MISC, SUB_IDLE};
      1: instr = {OPC_MISC, SUB_RET};
      2: instr = {OPC_MISC, SUB_IRQRET};
      3: instr = {OPC_RETLIT, r[7:0]};
      4: instr = {OPC_ROTL, r[15:8]};
      default: instr = {6'h11, r[7:0]};
    endcase
    instr_valid = 1;
    file_rdata = r[23:16];
    stack_top_entry = r[31:19];
    irq_entry = r[24] & r[25];
    ret = k >= 1 && k <= 3;
    rot = {r[22:16], 1'(m_c)};
    we = k == 4 && r[15];
    #1;
    chk(stack_pop, ret);
    if (k == 4) chk(file_raddr, r[14:8]);
    chk(foreign_op, k == 5);
    m_pc = ret ? int'(r[31:19]) : (m_pc + 1) % 8192;
    if (k == 3) m_acc = r[7:0];
    if (k == 4) begin
      m_c = r[23];
      if (!we) m_acc = rot;
    end
    if (k == 2) m_g = 1;
    else if (irq_entry) m_g = 0;
    @(posedge clk_sys);
    #1;
    chk(pc, m_pc);
    chk(acc, m_acc);
    chk(carry, m_c);
    chk(global_irq_allow, m_g);
    chk(irq_control_reg, m_g << 7);
    chk(instr_ready, !ret);
    chk(file_we, we);
    if (we) chk({file_waddr, file_wdata}, {r[14:8], 8'(rot)});
  endtask : op

  initial begin
    rst_n = 0;
    instr_valid = 0;
    instr = '0;
    stack_top_entry = '0;
    file_rdata = '0;
    irq_entry = 0;
    m_pc = 0;
    m_acc = 0;
    m_c = 0;
    m_g = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1;
    chk({pc, acc, carry, global_irq_allow, instr_ready, file_we}, {13'h0, 8'h0, 1'b0, 1'b0, 1'b1, 1'b0});
    for (int k = 0; k < 6; k++) op(k);
    repeat (400) op(rnd() % 6);
    instr_valid = 0;
    results();
  end
endmodule : tb
